// >>> bench/gpab_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpab_asserts
    import gpab_pkg::*;
(
    input wire logic                    MCLK,
    input wire logic                    RESET,
    input wire gpab_pkg::gpab_axi_req_t AXI_REQ,
    input wire gpab_pkg::gpab_axi_rsp_t AXI_RSP,
    input wire logic [7:0]              PA_OE,
    input wire logic [7:0]              PB_OE,
    input wire logic [7:0]              PB_PU,
    input wire logic                    CAPTURE_UNIT_TWO_PIN_SELECT,
    input wire logic                    UNIT_TWO_CAPTURE_IN,
    input wire logic                    DEBUG_EN,
    input wire logic                    DEBUG_CLOCK_IN,
    input wire logic                    DEBUG_DATA_IN,
    input wire logic                    PORT_CHANGE_IRQ,
    input wire logic                    WAKE_REQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    a_wr_answer: assert property (AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid
        && AXI_RSP.wready |-> ##[1:3] AXI_RSP.bvalid) else $error("write answer late");
    a_rd_answer: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
        else $error("read answer late");
    a_rd_blocks: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready)
        else $error("read taken while answer pending");
    a_pa_unimpl: assert property ((PA_OE & ~PA_IMPL) == 8'h00)
        else $error("unimplemented port a bit driven");
    a_pu_out_off: assert property ((PB_PU & PB_OE) == 8'h00)
        else $error("pull-up on an output pin");
    a_rst_quiet: assert property ($fell(RESET) |-> PB_PU == 8'h00 && PA_OE == 8'h00
        && PB_OE == 8'h00) else $error("drivers or pull-ups on after reset");
    a_wake_follow: assert property (WAKE_REQ == PORT_CHANGE_IRQ)
        else $error("wake request differs from change interrupt");
    a_dbg_off: assert property (!DEBUG_EN |=> !DEBUG_CLOCK_IN && !DEBUG_DATA_IN)
        else $error("debug inputs live while debug off");
    a_cap_gate: assert property (CAPTURE_UNIT_TWO_PIN_SELECT |=> !UNIT_TWO_CAPTURE_IN)
        else $error("capture input routed while not selected");
endmodule : gpab_asserts

bind gpab_ports gpab_asserts u_chk (.MCLK, .RESET, .AXI_REQ, .AXI_RSP, .PA_OE, .PB_OE, .PB_PU,
    .CAPTURE_UNIT_TWO_PIN_SELECT, .UNIT_TWO_CAPTURE_IN, .DEBUG_EN, .DEBUG_CLOCK_IN,
    .DEBUG_DATA_IN, .PORT_CHANGE_IRQ, .WAKE_REQ);
`default_nettype wire

// >>> bench/gpab_pins.sv
`timescale 1ns/1ps
`default_nettype none
// board side: an undriven port B pin without pull-up toggles every cycle, so stages 2 and 3 never agree and the port keeps its last settled level
module gpab_pins (
    input  wire logic       MCLK,
    input  wire logic [7:0] pa_o,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] pb_o,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pb_pu,
    input  wire logic [7:0] ext_a,
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_b_en,
    output var  logic [7:0] pa_lvl,
    output var  logic [7:0] pb_lvl
);
    logic flt_r = 1'b0;
    always_ff @(posedge MCLK) begin
        flt_r <= ~flt_r;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pa_lvl[i] = pa_oe[i] ? pa_o[i] : ext_a[i];
            pb_lvl[i] = pb_oe[i] ? pb_o[i]
                      : (ext_b_en[i] ? ext_b[i] : (pb_pu[i] | flt_r));
        end
    end
endmodule : gpab_pins
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gpab_pkg::*;
    logic          MCLK = 1'b0;
    logic          RESET = 1'b1;
    gpab_axi_req_t req = '0;
    gpab_axi_rsp_t rsp;
    logic [7:0]    pa_o, pa_oe, pb_o, pb_oe, pb_pu, pa_lvl, pb_lvl;
    logic [7:0]    ext_a = 8'hFF, ext_b = 8'h0F, ext_b_en = 8'hFF;
    logic          cmp1 = 1'b0, cmp2 = 1'b0, sel = 1'b1, u2 = 1'b0, u2_en = 1'b0, dbg = 1'b0;
    logic          cap_in, dclk_in, ddat_in, irq, prio, wake;
    logic [31:0]   rd;
    logic [1:0]    rr;
    int            error_cnt = 0, check_count = 0, cyc = 0;
    always #50 MCLK = ~MCLK;

    gpab_ports DUT (.MCLK(MCLK), .RESET(RESET), .AXI_REQ(req), .AXI_RSP(rsp), .PA_I(pa_lvl),
        .PA_O(pa_o), .PA_OE(pa_oe), .PB_I(pb_lvl), .PB_O(pb_o), .PB_OE(pb_oe), .PB_PU(pb_pu),
        .COMPARATOR_ONE_OUTPUT(cmp1), .COMPARATOR_TWO_OUTPUT(cmp2),
        .CAPTURE_UNIT_TWO_PIN_SELECT(sel), .UNIT_TWO_OUT(u2), .UNIT_TWO_OUT_EN(u2_en),
        .UNIT_TWO_CAPTURE_IN(cap_in), .DEBUG_EN(dbg), .DEBUG_DATA_OUT(u2),
        .DEBUG_DATA_OE(dbg), .DEBUG_CLOCK_IN(dclk_in), .DEBUG_DATA_IN(ddat_in),
        .PORT_CHANGE_IRQ(irq), .PORT_CHANGE_PRIORITY(prio), .WAKE_REQ(wake));
    gpab_pins u_pins (.MCLK(MCLK), .pa_o(pa_o), .pa_oe(pa_oe), .pb_o(pb_o), .pb_oe(pb_oe),
        .pb_pu(pb_pu), .ext_a(ext_a), .ext_b(ext_b), .ext_b_en(ext_b_en), .pa_lvl(pa_lvl),
        .pb_lvl(pb_lvl));

    task automatic stop_test;
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        rr = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge MCLK);
    endtask : wr

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] exp);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge MCLK);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge MCLK);
        chk(n, exp, rd);
    endtask : rchk

    task automatic t_reset;
        logic [7:0]  offs [8] = '{OFF_PA_DIR, OFF_PB_DIR, OFF_PA_LAT, OFF_PB_LAT, OFF_INT_MN,
                                  OFF_INT_EP, OFF_ANA_CFG, OFF_CMP_CFG};
        logic [31:0] rst [8] = '{32'(PA_DIR_RST), 32'(PB_DIR_RST), 32'(LAT_RST), 32'(LAT_RST),
                                 32'(INT_MN_RST), 32'(INT_EP_RST), {16'h0, PB_ANA_RST, PA_ANA_RST},
                                 32'(CMP_RST)};
        tick(8);
        foreach (offs[i]) rchk("reset value", offs[i], rst[i]);
        rchk("pin a analog", OFF_PA_PIN, 32'h00);
        rchk("pin b analog", OFF_PB_PIN, 32'h00);
        chk("pull-ups", 32'h0, 32'(pb_pu));
        rchk("unmapped", 8'h28, 32'h0);
        chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rr));
        wr(8'h28, 32'h55);
        chk("unmapped bresp", 32'(RESP_SLVERR), 32'(rr));
    endtask : t_reset

    task automatic t_port_a;
        wr(OFF_ANA_CFG, 32'h0);
        wr(OFF_PA_DIR, 32'h00);
        wr(OFF_PA_PIN, 32'h2D);
        tick(8);
        chk("pa oe", 32'(PA_IMPL), 32'(pa_oe));
        rchk("pa latch", OFF_PA_LAT, 32'h2D);
        rchk("pa pins", OFF_PA_PIN, 32'h2D);
        wr(OFF_ANA_CFG, 32'h2F);
        tick(8);
        chk("pa drive analog", 32'h2D, 32'(pa_o & pa_oe));
        rchk("pa analog read", OFF_PA_PIN, 32'h00);
        wr(OFF_ANA_CFG, 32'h0);
        wr(OFF_PA_DIR, 32'h2F);
        ext_a <= 8'h0E;
        tick(8);
        chk("pa float", 32'h0, 32'(pa_oe));
        rchk("pa input", OFF_PA_PIN, 32'h0E);
        wr(OFF_CMP_CFG, 32'h1);
        tick(8);
        rchk("pa cmp on", OFF_PA_PIN, 32'h00);
        wr(OFF_CMP_CFG, 32'hA);
        wr(OFF_PA_DIR, 32'h00);
        tick(8);
        chk("pa vref oe", 32'h2B, 32'(pa_oe));
        chk("pa c2 override", 32'h09, 32'(pa_o & pa_oe));
        rchk("pa vref read", OFF_PA_PIN, 32'h09);
    endtask : t_port_a

    task automatic t_port_b;
        wr(OFF_PB_DIR, 32'h00);
        wr(OFF_PB_LAT, 32'hA5);
        tick(2);
        chk("pb oe", 32'hFF, 32'(pb_oe));
        chk("pb o", 32'hA5, 32'(pb_o));
        rchk("pb latch", OFF_PB_LAT, 32'hA5);
        wr(OFF_INT_EP, 32'h00);
        wr(OFF_PB_DIR, 32'h0F);
        tick(2);
        chk("pull-ups on", 32'h0F, 32'(pb_pu));
        wr(OFF_INT_EP, 32'h80);
        tick(2);
        chk("pull-ups off", 32'h00, 32'(pb_pu));
    endtask : t_port_b

    task automatic t_change;
        wr(OFF_PB_DIR, 32'hFF);
        ext_b <= 8'h00;
        tick(8);
        rchk("pb rearm", OFF_PB_PIN, 32'h00);
        wr(OFF_INT_MN, 32'h08);
        tick(3);
        chk("irq idle", 32'h0, 32'(irq));
        ext_b <= 8'h10;
        tick(8);
        chk("irq", 32'h1, 32'(irq));
        chk("wake", 32'h1, 32'(wake));
        wr(OFF_INT_MN, 32'h08);
        rchk("flag held", OFF_INT_MN, 32'h09);
        rchk("pb read", OFF_PB_PIN, 32'h10);
        wr(OFF_INT_MN, 32'h08);
        tick(3);
        chk("irq cleared", 32'h0, 32'(irq));
        wr(OFF_PB_DIR, 32'h7F);
        ext_b <= 8'h1F;
        tick(8);
        chk("output and low pins excluded", 32'h0, 32'(irq));
        wr(OFF_INT_EP, 32'h81);
        tick(3);
        chk("priority", 32'h1, 32'(prio));
    endtask : t_change

    task automatic t_side;
        wr(OFF_PB_DIR, 32'h00);
        wr(OFF_PB_LAT, 32'h00);
        wr(OFF_CMP_CFG, 32'h4);
        cmp1 <= 1'b1;
        sel <= 1'b0;
        u2_en <= 1'b1;
        u2 <= 1'b1;
        tick(3);
        chk("pb overrides", 32'h28, 32'(pb_o));
        wr(OFF_PB_DIR, 32'hFF);
        ext_b <= 8'h48;
        dbg <= 1'b1;
        tick(8);
        chk("capture in", 32'h1, 32'(cap_in));
        chk("debug clock", 32'h1, 32'(dclk_in));
        chk("debug drive", 32'h101, 32'({pb_oe, ddat_in}));
        rchk("pb debug read", OFF_PB_PIN, 32'h08);
    endtask : t_side

    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        repeat (2) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        t_reset();
        t_port_a();
        t_port_b();
        t_change();
        t_side();
        stop_test();
    end
endmodule : tb
`default_nettype wire

// >>> rtl/gpab_pkg.sv
package gpab_pkg;

    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFF_PA_PIN  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PA_LAT  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PA_DIR  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_PB_PIN  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PB_LAT  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PB_DIR  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_INT_MN  = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_INT_EP  = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_ANA_CFG = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_CMP_CFG = 8'h24;

    localparam logic [7:0] PA_IMPL    = 8'h2F;
    localparam logic [7:0] PA_CMP_PIN = 8'h0F;
    localparam logic [7:0] PA_VREF    = 8'h04;
    localparam logic [7:0] PB_DBG     = 8'hC0;

    localparam logic [7:0] PA_DIR_RST = 8'h2F;
    localparam logic [7:0] PB_DIR_RST = 8'hFF;
    localparam logic [7:0] LAT_RST    = 8'h00;
    localparam logic [7:0] PA_ANA_RST = 8'h2F;
    localparam logic [7:0] PB_ANA_RST = 8'h1F;
    localparam logic [7:0] INT_MN_RST = 8'h00;
    localparam logic [7:0] INT_EP_RST = 8'h80;
    localparam logic [3:0] CMP_RST    = 4'h0;

    localparam int BIT_CHG_FLAG = 0;
    localparam int BIT_CHG_EN   = 3;
    localparam int BIT_PU_N     = 7;
    localparam int BIT_CHG_PRIO = 0;
    localparam int BIT_CMP_ON   = 0;
    localparam int BIT_VREF_OE  = 1;
    localparam int BIT_C1_OE    = 2;
    localparam int BIT_C2_OE    = 3;
    localparam int PIN_CAP2     = 3;
    localparam int PIN_C1       = 5;
    localparam int PIN_C2       = 5;
    localparam int PIN_DCLK     = 6;
    localparam int PIN_DDAT     = 7;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } gpab_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } gpab_axi_rsp_t;

endpackage : gpab_pkg

// >>> rtl/gpab_ports.sv
// How it works
// (RL1) port A has five pins: bits 0-3 and 5; other bits read zero
// (RL2) direction 1 floats the driver (input); 0 drives the latch onto the pin
// (RL3) pin register reads pin levels; writing it stores into the output latch
// (RL4) latch register is mapped and reads back the latch, not the pins
// (RL5) analog select per pin; analog pins read zero digitally
// (RL6) after reset port A pins 0-3 and 5 are analog, reading zero
// (RL7) comparators use pins 0,3 and 5; comparators on disables pins 0-3 digital input
// (RL8) direction bits still drive outputs on analog pins; software keeps them 1
// (RL9) reference output on pin A2 disables its digital output and input
// (RL10) output path drives the latch whatever the analog selection
// (RL11) port B: eight pins with direction, latch and pin registers like port A
// (RL12) clearing pull-up enable bit 7 turns on all port B weak pull-ups
// (RL13) pull-up off on output pins; all pull-ups off after reset
// (RL14) after reset port B pins 0-4 analog reading zero, 5-7 digital inputs
// (RL15) input pins B4-B7 compared to value latched at last read; mismatch sets flag
// (RL16) flag keeps setting while mismatch lasts; port B access re-arms reference
// (RL17) software reads or writes port B, then clears the flag
// (RL18) enabled port change event raises a wake request
// (RL19) software should not poll port B while change detection is used
// (RL20) select bit 0 puts unit-two output on B3 when output, capture when input
// (RL21) enabled comparator output overrides latch on B5 or A5 when output
// (RL22) debug enabled: B6 is debug clock in, B7 debug data, nothing else
// (RL23) change interrupt gated by enable bit 3; priority from bit 0
// (RL24) pin inputs are synchronised before reads and change detection
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gpab_ports
    import gpab_pkg::*;
(
    input  wire logic                   MCLK,
    input  wire logic                   RESET,
    input  wire gpab_pkg::gpab_axi_req_t AXI_REQ,
    output var  gpab_pkg::gpab_axi_rsp_t AXI_RSP,
    input  wire logic [7:0]             PA_I,
    output var  logic [7:0]             PA_O,
    output var  logic [7:0]             PA_OE,
    input  wire logic [7:0]             PB_I,
    output var  logic [7:0]             PB_O,
    output var  logic [7:0]             PB_OE,
    output var  logic [7:0]             PB_PU,
    input  wire logic                   COMPARATOR_ONE_OUTPUT,
    input  wire logic                   COMPARATOR_TWO_OUTPUT,
    input  wire logic                   CAPTURE_UNIT_TWO_PIN_SELECT,
    input  wire logic                   UNIT_TWO_OUT,
    input  wire logic                   UNIT_TWO_OUT_EN,
    output var  logic                   UNIT_TWO_CAPTURE_IN,
    input  wire logic                   DEBUG_EN,
    input  wire logic                   DEBUG_DATA_OUT,
    input  wire logic                   DEBUG_DATA_OE,
    output var  logic                   DEBUG_CLOCK_IN,
    output var  logic                   DEBUG_DATA_IN,
    output var  logic                   PORT_CHANGE_IRQ,
    output var  logic                   PORT_CHANGE_PRIORITY,
    output var  logic                   WAKE_REQ
);
    import gpab_pkg::*;

    logic [7:0] pa_s1_r, pa_s2_r, pa_s3_r, pa_f_r;
    logic [7:0] pb_s1_r, pb_s2_r, pb_s3_r, pb_f_r;
    logic [7:0] pa_lat_r, pa_dir_r, pb_lat_r, pb_dir_r;
    logic [7:0] pa_ana_r, pb_ana_r;
    logic [3:0] cmp_r;
    logic [7:0] int_mn_r, int_ep_r;
    logic [7:4] chg_ref_r;
    logic       chg_flag_r;

    logic              aw_got_r, w_got_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              wr_fire;
    logic              rd_fire;
    logic [7:0]        pa_dig, pb_dig;
    logic [7:4]        mismatch;
    logic              chg_req;

    // one function serves both write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = ({a[ADDR_W-1:2], 2'b00} == off);
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, OFF_PA_PIN) | hit(a, OFF_PA_LAT) | hit(a, OFF_PA_DIR)
               | hit(a, OFF_PB_PIN) | hit(a, OFF_PB_LAT) | hit(a, OFF_PB_DIR)
               | hit(a, OFF_INT_MN) | hit(a, OFF_INT_EP)
               | hit(a, OFF_ANA_CFG) | hit(a, OFF_CMP_CFG);
    endfunction : mapped

    // a bit keeps its old level while stages 2 and 3 disagree
    function automatic logic [7:0] settle(input logic [7:0] s2, s3, f);
        settle = (s2 & ~(s2 ^ s3)) | (f & (s2 ^ s3));
    endfunction : settle

    // 3-stage synchroniser; a change is accepted once stages 2 and 3 agree
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pa_s1_r <= 8'h00;
            pa_s2_r <= 8'h00;
            pa_s3_r <= 8'h00;
            pa_f_r  <= 8'h00;
            pb_s1_r <= 8'h00;
            pb_s2_r <= 8'h00;
            pb_s3_r <= 8'h00;
            pb_f_r  <= 8'h00;
        end else begin
            pa_s1_r <= PA_I;
            pa_s2_r <= pa_s1_r;
            pa_s3_r <= pa_s2_r;
            pb_s1_r <= PB_I;
            pb_s2_r <= pb_s1_r;
            pb_s3_r <= pb_s2_r;
            pa_f_r  <= settle(pa_s2_r, pa_s3_r, pa_f_r); // see RL24
            pb_f_r  <= settle(pb_s2_r, pb_s3_r, pb_f_r); // see RL24
        end
    end

    // digital read paths: analog, comparator and reference uses force zero
    always_comb begin
        pa_dig = pa_f_r & PA_IMPL & ~pa_ana_r; // see RL1 see RL5
        if (cmp_r[BIT_CMP_ON]) begin
            pa_dig = pa_dig & ~PA_CMP_PIN; // see RL7
        end
        if (cmp_r[BIT_VREF_OE]) begin
            pa_dig = pa_dig & ~PA_VREF; // see RL9
        end
        pb_dig = pb_f_r & ~pb_ana_r; // see RL11
        if (DEBUG_EN) begin
            pb_dig = pb_dig & ~PB_DBG; // see RL22
        end
    end

    // AXI4-Lite write side: address and data taken in either order
    // readies stay low until the response is taken: one write at a time
    assign wr_fire = aw_got_r & w_got_r & ~AXI_RSP.bvalid;
    assign rd_fire = AXI_REQ.arvalid & AXI_RSP.arready;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            aw_got_r        <= 1'b0;
            w_got_r         <= 1'b0;
            aw_addr_r       <= '0;
            w_data_r        <= 32'h0000_0000;
            w_strb_r        <= 4'h0;
            AXI_RSP.awready <= 1'b1;
            AXI_RSP.wready  <= 1'b1;
            AXI_RSP.bvalid  <= 1'b0;
            AXI_RSP.bresp   <= RESP_OKAY;
        end else begin
            if (AXI_REQ.awvalid && AXI_RSP.awready) begin
                aw_got_r        <= 1'b1;
                aw_addr_r       <= AXI_REQ.awaddr;
                AXI_RSP.awready <= 1'b0;
            end
            if (AXI_REQ.wvalid && AXI_RSP.wready) begin
                w_got_r        <= 1'b1;
                w_data_r       <= AXI_REQ.wdata;
                w_strb_r       <= AXI_REQ.wstrb;
                AXI_RSP.wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_r       <= 1'b0;
                w_got_r        <= 1'b0;
                AXI_RSP.bvalid <= 1'b1;
                AXI_RSP.bresp  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            if (AXI_RSP.bvalid && AXI_REQ.bready) begin
                AXI_RSP.bvalid  <= 1'b0;
                AXI_RSP.awready <= 1'b1;
                AXI_RSP.wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side: data registered one cycle after the address
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            AXI_RSP.arready <= 1'b1;
            AXI_RSP.rvalid  <= 1'b0;
            AXI_RSP.rdata   <= 32'h0000_0000;
            AXI_RSP.rresp   <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                AXI_RSP.arready <= 1'b0;
                AXI_RSP.rvalid  <= 1'b1;
                AXI_RSP.rresp   <= mapped(AXI_REQ.araddr) ? RESP_OKAY : RESP_SLVERR;
                AXI_RSP.rdata   <= 32'h0000_0000;
                unique case (1'b1)
                    hit(AXI_REQ.araddr, OFF_PA_PIN):
                        AXI_RSP.rdata[7:0] <= pa_dig; // see RL3
                    hit(AXI_REQ.araddr, OFF_PA_LAT):
                        AXI_RSP.rdata[7:0] <= pa_lat_r; // see RL4
                    hit(AXI_REQ.araddr, OFF_PA_DIR):
                        AXI_RSP.rdata[7:0] <= pa_dir_r;
                    hit(AXI_REQ.araddr, OFF_PB_PIN):
                        AXI_RSP.rdata[7:0] <= pb_dig; // see RL3
                    hit(AXI_REQ.araddr, OFF_PB_LAT):
                        AXI_RSP.rdata[7:0] <= pb_lat_r; // see RL4
                    hit(AXI_REQ.araddr, OFF_PB_DIR):
                        AXI_RSP.rdata[7:0] <= pb_dir_r;
                    hit(AXI_REQ.araddr, OFF_INT_MN): begin
                        AXI_RSP.rdata[7:0] <= int_mn_r;
                        AXI_RSP.rdata[BIT_CHG_FLAG] <= chg_flag_r;
                    end
                    hit(AXI_REQ.araddr, OFF_INT_EP):
                        AXI_RSP.rdata[7:0] <= int_ep_r;
                    hit(AXI_REQ.araddr, OFF_ANA_CFG):
                        AXI_RSP.rdata[15:0] <= {pb_ana_r, pa_ana_r};
                    hit(AXI_REQ.araddr, OFF_CMP_CFG):
                        AXI_RSP.rdata[3:0] <= cmp_r;
                    default: ;
                endcase
            end
            if (AXI_RSP.rvalid && AXI_REQ.rready) begin
                AXI_RSP.rvalid  <= 1'b0;
                AXI_RSP.arready <= 1'b1;
            end
        end
    end

    // latches and directions; writes to a pin register land in its latch
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pa_lat_r <= LAT_RST;
            pb_lat_r <= LAT_RST;
            pa_dir_r <= PA_DIR_RST;
            pb_dir_r <= PB_DIR_RST;
        end else if (wr_fire && w_strb_r[0]) begin
            if (hit(aw_addr_r, OFF_PA_PIN) || hit(aw_addr_r, OFF_PA_LAT)) begin
                pa_lat_r <= w_data_r[7:0] & PA_IMPL; // see RL3 see RL1
            end
            if (hit(aw_addr_r, OFF_PB_PIN) || hit(aw_addr_r, OFF_PB_LAT)) begin
                pb_lat_r <= w_data_r[7:0]; // see RL3 see RL11
            end
            if (hit(aw_addr_r, OFF_PA_DIR)) begin
                pa_dir_r <= w_data_r[7:0] & PA_IMPL;
            end
            if (hit(aw_addr_r, OFF_PB_DIR)) begin
                pb_dir_r <= w_data_r[7:0];
            end
        end
    end

    // analog and comparator selection; resets to analog on the shared pins
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pa_ana_r <= PA_ANA_RST; // see RL6
            pb_ana_r <= PB_ANA_RST; // see RL14
            cmp_r    <= CMP_RST;
        end else if (wr_fire) begin
            if (hit(aw_addr_r, OFF_ANA_CFG) && w_strb_r[0]) begin
                pa_ana_r <= w_data_r[7:0] & PA_IMPL; // see RL5
            end
            if (hit(aw_addr_r, OFF_ANA_CFG) && w_strb_r[1]) begin
                pb_ana_r <= w_data_r[15:8];
            end
            if (hit(aw_addr_r, OFF_CMP_CFG) && w_strb_r[0]) begin
                cmp_r <= w_data_r[3:0];
            end
        end
    end

    // interrupt control bits; the flag lives apart so hardware can set it
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            int_mn_r <= INT_MN_RST;
            int_ep_r <= INT_EP_RST; // see RL13
        end else if (wr_fire && w_strb_r[0]) begin
            if (hit(aw_addr_r, OFF_INT_MN)) begin
                int_mn_r <= '0;
                int_mn_r[BIT_CHG_EN] <= w_data_r[BIT_CHG_EN]; // see RL23
            end
            if (hit(aw_addr_r, OFF_INT_EP)) begin
                int_ep_r <= '0;
                int_ep_r[BIT_PU_N]     <= w_data_r[BIT_PU_N]; // see RL12
                int_ep_r[BIT_CHG_PRIO] <= w_data_r[BIT_CHG_PRIO]; // see RL23
            end
        end
    end

    // change detect on input pins 7:4 only; output pins never mismatch
    // debug owns B6/B7, so a stale reference there must not fire
    assign mismatch = (pb_dig[7:4] ^ chg_ref_r) & pb_dir_r[7:4] // see RL15
                    & ~(DEBUG_EN ? PB_DBG[7:4] : 4'h0); // see RL22
    // wake and interrupt share one term so they cannot drift apart
    assign chg_req  = chg_flag_r && int_mn_r[BIT_CHG_EN];

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            chg_ref_r  <= 4'h0;
            chg_flag_r <= 1'b0;
        end else begin
            // any bus access to the port B pin register re-arms the reference
            if ((rd_fire && hit(AXI_REQ.araddr, OFF_PB_PIN))
                || (wr_fire && hit(aw_addr_r, OFF_PB_PIN))) begin
                chg_ref_r <= pb_dig[7:4]; // see RL16 see RL17
            end
            // set wins over a same-cycle software clear
            if (|mismatch) begin
                chg_flag_r <= 1'b1; // see RL15 see RL16
            end else if (wr_fire && w_strb_r[0] && hit(aw_addr_r, OFF_INT_MN)) begin
                chg_flag_r <= w_data_r[BIT_CHG_FLAG];
            end
        end
    end

    // pin drivers; analog selection never blocks the output path
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            PA_O  <= 8'h00;
            PA_OE <= 8'h00;
            PB_O  <= 8'h00;
            PB_OE <= 8'h00;
            PB_PU <= 8'h00;
        end else begin
            PA_OE <= ~pa_dir_r & PA_IMPL // see RL2 see RL8 see RL10
                   & ~(cmp_r[BIT_VREF_OE] ? PA_VREF : 8'h00); // see RL9
            PA_O  <= pa_lat_r;
            if (cmp_r[BIT_C2_OE] && !pa_dir_r[PIN_C2]) begin
                PA_O[PIN_C2] <= COMPARATOR_TWO_OUTPUT; // see RL21 see RL7
            end
            PB_OE <= ~pb_dir_r; // see RL2 see RL11
            PB_O  <= pb_lat_r;
            PB_PU <= int_ep_r[BIT_PU_N] ? 8'h00 : pb_dir_r; // see RL12 see RL13
            if (!CAPTURE_UNIT_TWO_PIN_SELECT && UNIT_TWO_OUT_EN && !pb_dir_r[PIN_CAP2]) begin
                PB_O[PIN_CAP2] <= UNIT_TWO_OUT; // see RL20
            end
            if (cmp_r[BIT_C1_OE] && !pb_dir_r[PIN_C1]) begin
                PB_O[PIN_C1] <= COMPARATOR_ONE_OUTPUT; // see RL21
            end
            if (DEBUG_EN) begin
                PB_OE[PIN_DCLK] <= 1'b0; // see RL22
                PB_OE[PIN_DDAT] <= DEBUG_DATA_OE;
                PB_O[PIN_DCLK]  <= 1'b0;
                PB_O[PIN_DDAT]  <= DEBUG_DATA_OUT;
                PB_PU[PIN_DCLK] <= 1'b0;
                PB_PU[PIN_DDAT] <= 1'b0;
            end
        end
    end

    // side-band outputs toward peripherals and the power controller
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            UNIT_TWO_CAPTURE_IN  <= 1'b0;
            DEBUG_CLOCK_IN       <= 1'b0;
            DEBUG_DATA_IN        <= 1'b0;
            PORT_CHANGE_IRQ      <= 1'b0;
            PORT_CHANGE_PRIORITY <= 1'b0;
            WAKE_REQ             <= 1'b0;
        end else begin
            UNIT_TWO_CAPTURE_IN <= !CAPTURE_UNIT_TWO_PIN_SELECT
                                 && pb_dir_r[PIN_CAP2] && pb_f_r[PIN_CAP2]; // see RL20
            DEBUG_CLOCK_IN <= DEBUG_EN && pb_f_r[PIN_DCLK]; // see RL22
            DEBUG_DATA_IN  <= DEBUG_EN && pb_f_r[PIN_DDAT];
            PORT_CHANGE_IRQ      <= chg_req; // see RL23
            PORT_CHANGE_PRIORITY <= int_ep_r[BIT_CHG_PRIO];
            WAKE_REQ             <= chg_req; // see RL18
        end
    end

endmodule : gpab_ports
`default_nettype wire
